// ==== common/sepec_map.vh ====
// Opcodes, status layout, protection map and timing constants of the erase/protect controller
`ifndef SEPEC_MAP_VH
`define SEPEC_MAP_VH
`define SEPEC_OP_LATCH_SET      8'h06
`define SEPEC_OP_LATCH_CLEAR    8'h04
`define SEPEC_OP_STATUS_READ    8'h05
`define SEPEC_OP_STATUS_WRITE   8'h01
`define SEPEC_OP_PAGE_ERASE     8'h42
`define SEPEC_OP_SECTOR_ERASE   8'hD8
`define SEPEC_OP_CHIP_ERASE     8'hC7
`define SEPEC_OP_POWER_DOWN     8'hB9
`define SEPEC_OP_RELEASE_SIG    8'hAB
`define SEPEC_SR_PPE            7
`define SEPEC_SR_BP_HI          3
`define SEPEC_SR_BP_LO          2
`define SEPEC_SR_WEL            1
`define SEPEC_SR_BUSY           0
`define SEPEC_BP_NONE           2'h0
`define SEPEC_BP_QUARTER        2'h1
`define SEPEC_BP_HALF           2'h2
`define SEPEC_BP_ALL            2'h3
`define SEPEC_QUARTER_BASE      17'h18000
`define SEPEC_HALF_BASE         17'h10000
`define SEPEC_OP_BITS           6'h08
`define SEPEC_ADDR_END_BITS     6'h20
`define SEPEC_DATA_END_BITS     6'h10
`define SEPEC_CNT_TOP           6'h3F
`define SEPEC_CNT_WRAP          6'h38
`define SEPEC_CLK_MHZ           50
`define SEPEC_PAGE_ERASE_MS     6
`define SEPEC_SECTOR_ERASE_MS   10
`define SEPEC_CHIP_ERASE_MS     10
`define SEPEC_STATUS_WRITE_MS   6
`define SEPEC_DP_SETTLE_US      3
`define SEPEC_REL_US            3
`endif

// ==== logic/sepec_ctrl.v ====
// Serial EEPROM command control: write latch, status, block protection, erase and deep power-down
`timescale 1ns/1ps
`include "sepec_map.vh"
module sepec_ctrl #(
    parameter PAGE_ERASE_CYC   = `SEPEC_PAGE_ERASE_MS * 1000 * `SEPEC_CLK_MHZ,
    parameter SECTOR_ERASE_CYC = `SEPEC_SECTOR_ERASE_MS * 1000 * `SEPEC_CLK_MHZ,
    parameter CHIP_ERASE_CYC   = `SEPEC_CHIP_ERASE_MS * 1000 * `SEPEC_CLK_MHZ,
    parameter STATUS_WRITE_CYC = `SEPEC_STATUS_WRITE_MS * 1000 * `SEPEC_CLK_MHZ,
    parameter DP_SETTLE_CYC    = `SEPEC_DP_SETTLE_US * `SEPEC_CLK_MHZ,
    parameter REL_CYC          = `SEPEC_REL_US * `SEPEC_CLK_MHZ,
    parameter [7:0] SIGNATURE  = 8'h5A,   // Arbitrary signature value
    parameter [7:0] NV_INIT    = 8'h00    // Power-on value of nonvolatile bits
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        cs_n,
    input  wire        sck,
    input  wire        si,
    input  wire        wp_n,
    output reg         so_ff,
    output reg         so_oe_n_ff,
    output reg         erase_req_ff,
    output reg  [1:0]  erase_kind_ff,
    output reg  [16:0] erase_addr_ff,
    output reg         power_down_ff,
    output reg         low_power_ff,
    output reg  [7:0]  status_ff
);

localparam [1:0] KIND_PAGE   = 2'h0;
localparam [1:0] KIND_SECTOR = 2'h1;
localparam [1:0] KIND_CHIP   = 2'h2;
localparam [1:0] KIND_STATUS = 2'h3;

localparam [1:0] ST_STANDBY = 2'h0;
localparam [1:0] ST_BUSY    = 2'h1;
localparam [1:0] ST_DPD     = 2'h2;
localparam [1:0] ST_REL     = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

reg  [1:0]  cs_sync_ff;
reg  [1:0]  sck_sync_ff;
reg  [1:0]  si_sync_ff;
reg  [1:0]  wp_sync_ff;
reg         sck_prev_ff;
reg         cs_prev_ff;

// Reset values equal the idle pin levels, so no false edge follows reset
wire cs_q      = cs_sync_ff[1];
wire sck_rise  = sck_sync_ff[1] & ~sck_prev_ff;
wire sck_fall  = ~sck_sync_ff[1] & sck_prev_ff;
wire cs_rise   = cs_q & ~cs_prev_ff;

always @(posedge mclk) begin
    if (reset) begin
        cs_sync_ff  <= 2'h3;
        sck_sync_ff <= 2'h0;
        si_sync_ff  <= 2'h0;
        wp_sync_ff  <= 2'h3;
        sck_prev_ff <= 1'b0;
        cs_prev_ff  <= 1'b1;
    end else begin
        cs_sync_ff  <= {cs_sync_ff[0], cs_n};
        sck_sync_ff <= {sck_sync_ff[0], sck};
        si_sync_ff  <= {si_sync_ff[0], si};
        wp_sync_ff  <= {wp_sync_ff[0], wp_n};
        sck_prev_ff <= sck_sync_ff[1];
        cs_prev_ff  <= cs_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Protection helper

// True when the 17-bit address lies inside the area fenced by the protect code
function addr_locked;
    input [1:0]  bp;
    input [16:0] addr;
    begin
        case (bp)
            `SEPEC_BP_NONE:    addr_locked = 1'b0;
            `SEPEC_BP_QUARTER: addr_locked = (addr >= `SEPEC_QUARTER_BASE);
            `SEPEC_BP_HALF:    addr_locked = (addr >= `SEPEC_HALF_BASE);
            default:           addr_locked = 1'b1;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Delay helpers

// Self-timed delays count down to one; the last cycle hands over to the next state, except in ST_DPD, where it raises low_power_ff
function timer_last;
    input [31:0] t;
    begin
        timer_last = (t <= 32'h1);
    end
endfunction

function [31:0] timer_step;
    input [31:0] t;
    begin
        timer_step = t - 32'h1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Serial frame capture

reg  [5:0]  bit_cnt_ff;
reg  [7:0]  op_ff;
reg  [23:0] arg_ff;
reg  [7:0]  tx_ff;
reg  [1:0]  state_ff;
reg  [31:0] timer_ff;
reg  [1:0]  kind_ff;
reg         wel_ff;
reg         ppe_ff;
reg  [1:0]  bp_ff;
reg  [7:0]  nv_pend_ff;

reg  [5:0]  nxt_bit_cnt;
reg  [7:0]  nxt_op;
reg  [23:0] nxt_arg;

wire busy      = (state_ff == ST_BUSY);
wire in_dpd    = (state_ff == ST_DPD);
wire [7:0] sr  = {ppe_ff, 3'h0, bp_ff, wel_ff, busy};
wire [16:0] ea = arg_ff[16:0];
wire sr_locked = ppe_ff & ~wp_sync_ff[1];

always @* begin
    nxt_bit_cnt = bit_cnt_ff;
    nxt_op      = op_ff;
    nxt_arg     = arg_ff;
    if (sck_rise && !cs_q) begin
        // Long reads wrap inside the last byte slot so the byte reload keeps firing
        if (bit_cnt_ff == `SEPEC_CNT_TOP) begin
            nxt_bit_cnt = `SEPEC_CNT_WRAP;
        end else begin
            nxt_bit_cnt = bit_cnt_ff + 6'h01;
        end
        if (bit_cnt_ff < `SEPEC_OP_BITS) begin
            nxt_op = {op_ff[6:0], si_sync_ff[1]};
        end else begin
            nxt_arg = {arg_ff[22:0], si_sync_ff[1]};
        end
    end
end

always @(posedge mclk) begin
    if (reset || cs_q) begin
        bit_cnt_ff <= 6'h00;
    end else begin
        bit_cnt_ff <= nxt_bit_cnt;
    end
    if (reset) begin
        op_ff  <= 8'h00;
        arg_ff <= 24'h000000;
    end else begin
        op_ff  <= nxt_op;
        arg_ff <= nxt_arg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial output: status repeats, signature after dummy address

wire in_sr_read = (op_ff == `SEPEC_OP_STATUS_READ) && (bit_cnt_ff >= `SEPEC_OP_BITS) && !in_dpd;
wire in_sig     = (op_ff == `SEPEC_OP_RELEASE_SIG) && (bit_cnt_ff >= `SEPEC_ADDR_END_BITS);

always @(posedge mclk) begin
    if (reset) begin
        so_ff      <= 1'b0;
        so_oe_n_ff <= 1'b1;
        tx_ff      <= 8'h00;
    end else if (cs_q) begin
        so_oe_n_ff <= 1'b1;
    end else if (sck_fall && (in_sr_read || in_sig)) begin
        // Reload on byte boundary so a busy change shows on the next byte
        if (bit_cnt_ff[2:0] == 3'h0) begin
            so_ff <= in_sig ? SIGNATURE[7] : sr[7];
            tx_ff <= in_sig ? {SIGNATURE[6:0], 1'b0} : {sr[6:0], 1'b0};
        end else begin
            so_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
        so_oe_n_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Command execution at deselect; release from power-down at the eighth bit

wire at_op_end   = (bit_cnt_ff == `SEPEC_OP_BITS);
wire at_data_end = (bit_cnt_ff == `SEPEC_DATA_END_BITS);
wire at_addr_end = (bit_cnt_ff == `SEPEC_ADDR_END_BITS);

always @(posedge mclk) begin
    if (reset) begin
        state_ff   <= ST_STANDBY;
        wel_ff     <= 1'b0;
        ppe_ff     <= NV_INIT[`SEPEC_SR_PPE];
        bp_ff      <= NV_INIT[`SEPEC_SR_BP_HI:`SEPEC_SR_BP_LO];
        timer_ff   <= 32'h0;
        kind_ff    <= KIND_PAGE;
        nv_pend_ff <= 8'h00;
        erase_req_ff  <= 1'b0;
        erase_kind_ff <= KIND_PAGE;
        erase_addr_ff <= 17'h00000;
        low_power_ff  <= 1'b0;
    end else begin
        erase_req_ff <= 1'b0;
        case (state_ff)
            ST_STANDBY: begin
                if (cs_rise && at_op_end) begin
                    case (op_ff)
                        `SEPEC_OP_LATCH_SET:   wel_ff <= 1'b1;
                        `SEPEC_OP_LATCH_CLEAR: wel_ff <= 1'b0;
                        `SEPEC_OP_CHIP_ERASE: begin
                            if (wel_ff && bp_ff == `SEPEC_BP_NONE) begin
                                wel_ff        <= 1'b0;
                                kind_ff       <= KIND_CHIP;
                                timer_ff      <= CHIP_ERASE_CYC;
                                state_ff      <= ST_BUSY;
                                erase_req_ff  <= 1'b1;
                                erase_kind_ff <= KIND_CHIP;
                                erase_addr_ff <= 17'h00000;
                            end
                        end
                        `SEPEC_OP_POWER_DOWN: begin
                            state_ff <= ST_DPD;
                            timer_ff <= DP_SETTLE_CYC;
                        end
                        default: ;
                    endcase
                end else if (cs_rise && at_data_end && op_ff == `SEPEC_OP_STATUS_WRITE) begin
                    if (wel_ff && !sr_locked) begin
                        wel_ff     <= 1'b0;
                        nv_pend_ff <= arg_ff[7:0];
                        kind_ff    <= KIND_STATUS;
                        timer_ff   <= STATUS_WRITE_CYC;
                        state_ff   <= ST_BUSY;
                    end
                end else if (cs_rise && at_addr_end &&
                             (op_ff == `SEPEC_OP_PAGE_ERASE || op_ff == `SEPEC_OP_SECTOR_ERASE)) begin
                    if (wel_ff) begin
                        wel_ff <= 1'b0;
                        if (!addr_locked(bp_ff, ea)) begin
                            state_ff      <= ST_BUSY;
                            erase_req_ff  <= 1'b1;
                            erase_addr_ff <= ea;
                            if (op_ff == `SEPEC_OP_PAGE_ERASE) begin
                                kind_ff       <= KIND_PAGE;
                                erase_kind_ff <= KIND_PAGE;
                                timer_ff      <= PAGE_ERASE_CYC;
                            end else begin
                                kind_ff       <= KIND_SECTOR;
                                erase_kind_ff <= KIND_SECTOR;
                                timer_ff      <= SECTOR_ERASE_CYC;
                            end
                        end
                    end
                end
            end
            ST_BUSY: begin
                // Array commands are dropped here; status read and the signature read still answer
                if (!timer_last(timer_ff)) begin
                    timer_ff <= timer_step(timer_ff);
                end else begin
                    state_ff <= ST_STANDBY;
                    if (kind_ff == KIND_STATUS) begin
                        ppe_ff <= nv_pend_ff[`SEPEC_SR_PPE];
                        bp_ff  <= nv_pend_ff[`SEPEC_SR_BP_HI:`SEPEC_SR_BP_LO];
                    end
                end
            end
            ST_DPD: begin
                if (!timer_last(timer_ff)) begin
                    timer_ff <= timer_step(timer_ff);
                end else begin
                    low_power_ff <= 1'b1;
                end
                // Release begins at the eighth bit; the signature may follow in the same frame
                if (!cs_q && at_op_end && op_ff == `SEPEC_OP_RELEASE_SIG) begin
                    state_ff     <= ST_REL;
                    timer_ff     <= REL_CYC;
                    low_power_ff <= 1'b0;
                end
            end
            ST_REL: begin
                if (!timer_last(timer_ff)) begin
                    timer_ff <= timer_step(timer_ff);
                end else begin
                    state_ff <= ST_STANDBY;
                end
            end
            default: state_ff <= ST_STANDBY;
        endcase
    end
end

always @(posedge mclk) begin
    if (reset) begin
        power_down_ff <= 1'b0;
        status_ff     <= 8'h00;
    end else begin
        power_down_ff <= in_dpd;
        status_ff     <= sr;
    end
end

endmodule // sepec_ctrl

// ==== sim/sepec_host.sv ====
// SPI host model that frames commands into the controller
`timescale 1ns/1ps
module sepec_host (
    input  wire mclk,
    input  wire so,
    output reg  cs_n,
    output reg  sck,
    output reg  si
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    task tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Clock idles low between frames; data flips on release so a stale bit never looks valid
    task frame(input [39:0] tx, input integer n, output [7:0] rx);
        integer i;
        tick(1);
        cs_n = 1'b0;
        for (i = 0; i < n; i = i + 1) begin
            si = (i < 40) ? tx[39-i] : 1'b0;
            tick(4);
            sck = 1'b1;
            rx = {rx[6:0], so};
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(6);
    endtask
endmodule // sepec_host

// ==== sim/sepec_checker.sv ====
// Concurrent checks on the controller ports
`timescale 1ns/1ps
module sepec_checker (
    input wire        mclk,
    input wire        reset,
    input wire        cs_n,
    input wire        so_oe_n_ff,
    input wire        erase_req_ff,
    input wire [1:0]  erase_kind_ff,
    input wire [16:0] erase_addr_ff,
    input wire        power_down_ff,
    input wire        low_power_ff,
    input wire [7:0]  status_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_busy_on;
        ##[0:2] status_ff[0];
    endsequence
    sequence s_deselected;
        cs_n [*6];
    endsequence
    a_erase_busy_on: assert property (erase_req_ff |-> s_busy_on)
        else $error("busy not raised by erase");
    a_erase_clears_wel: assert property (erase_req_ff |-> ##[1:3] !status_ff[1])
        else $error("latch kept after erase");
    a_erase_needs_wel: assert property (erase_req_ff |-> $past(status_ff[1]))
        else $error("erase without latch");
    a_chip_unprot: assert property (erase_req_ff && erase_kind_ff == 2'h2 |-> status_ff[3:2] == 2'h0)
        else $error("chip erase while protected");
    a_block_abort: assert property (erase_req_ff |-> !(status_ff[3:2] == 2'h3 ||
        (status_ff[3:2] == 2'h2 && erase_addr_ff[16]) || (status_ff[3:2] == 2'h1 && erase_addr_ff[16:15] == 2'h3)))
        else $error("erase into protected block");
    a_busy_stands: assert property ($rose(status_ff[0]) |=> status_ff[0] [*8])
        else $error("busy dropped early");
    a_oe_idle: assert property (s_deselected |-> so_oe_n_ff)
        else $error("output driven while deselected");
    a_settle_bound: assert property ($rose(power_down_ff) |-> !low_power_ff ##[1:1000] low_power_ff)
        else $error("settle delay wrong");
    a_pd_quiet: assert property (power_down_ff |-> !erase_req_ff)
        else $error("erase in power-down");
    a_unused_zero: assert property (status_ff[6:4] == 3'h0)
        else $error("unused status bits set");
endmodule // sepec_checker
bind sepec_ctrl sepec_checker u_chk (.mclk(mclk), .reset(reset), .cs_n(cs_n), .so_oe_n_ff(so_oe_n_ff),
    .erase_req_ff(erase_req_ff), .erase_kind_ff(erase_kind_ff), .erase_addr_ff(erase_addr_ff),
    .power_down_ff(power_down_ff), .low_power_ff(low_power_ff), .status_ff(status_ff));

// ==== sim/tb.sv ====
// Self-checking bench for the erase and protection controller
`timescale 1ns/1ps
module tb;
    reg         mclk = 1'b0;
    reg         reset = 1'b1;
    reg         wp_n = 1'b1;
    wire        cs_n, sck, si, so_ff, so_oe_n_ff, erase_req_ff, power_down_ff, low_power_ff;
    wire [1:0]  erase_kind_ff;
    wire [16:0] erase_addr_ff;
    wire [7:0]  status_ff;
    // Released output reads inverted, so a late or missing enable corrupts the sample
    wire        so_pin = so_oe_n_ff ? ~so_ff : so_ff;
    integer     failures = 0, cmp_count = 0, seed = 35721, cyc = 0, reqs = 0, n, i;
    reg  [7:0]  rx;
    reg  [31:0] r;
    reg  [1:0]  bp, last_kind;
    reg  [16:0] last_addr;
    always #10 mclk = ~mclk;
    sepec_ctrl #(.PAGE_ERASE_CYC(300), .SECTOR_ERASE_CYC(400), .CHIP_ERASE_CYC(600), .STATUS_WRITE_CYC(350),
        .SIGNATURE(8'hC3)) u_dut (.mclk(mclk), .reset(reset), .cs_n(cs_n),
        .sck(sck), .si(si), .wp_n(wp_n), .so_ff(so_ff), .so_oe_n_ff(so_oe_n_ff), .erase_req_ff(erase_req_ff),
        .erase_kind_ff(erase_kind_ff), .erase_addr_ff(erase_addr_ff), .power_down_ff(power_down_ff),
        .low_power_ff(low_power_ff), .status_ff(status_ff));
    sepec_host u_host (.mclk(mclk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si));
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %0s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task op(input [39:0] tx, input integer bits);
        u_host.frame(tx, bits, rx);
    endtask
    task wen;
        op({8'h06, 32'h0}, 8);
    endtask
    task status_write_cmd(input [7:0] v);
        op({8'h01, v, 24'h0}, 16);
    endtask
    task status_read_cmd;
        op({8'h05, 32'h0}, 16);
    endtask
    // Polls busy a bounded number of times; rx holds the last status read
    task idle;
        status_read_cmd;
        repeat (20) if (rx[0] !== 1'b0) status_read_cmd;
    endtask
    function prot(input [1:0] b, input [16:0] ad);
        prot = b == 2'h3 || (b == 2'h2 && ad >= 17'h10000) || (b == 2'h1 && ad >= 17'h18000);
    endfunction
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (erase_req_ff === 1'b1) begin
            reqs = reqs + 1;
            last_kind = erase_kind_ff;
            last_addr = erase_addr_ff;
        end
        if (cyc > 90000) begin
            failures = failures + 1;
            end_sim;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        chk("oe_n", so_oe_n_ff, 1);
        chk("status", status_ff, 0);
        chk("pd", power_down_ff, 0);
        $display("test reset done");
        op({8'h06, 32'h0}, 9);
        status_read_cmd;
        chk("wel_short", rx, 0);
        wen;
        status_read_cmd;
        chk("wel_set", rx, 8'h02);
        op({8'h05, 32'h0}, 72);
        chk("sr_repeat", rx, 8'h02);
        op({8'h04, 32'h0}, 8);
        status_read_cmd;
        chk("wel_clr", rx, 0);
        status_write_cmd(8'h8C);
        idle;
        chk("status_write_cmd_locked", rx, 0);
        wen;
        status_write_cmd(8'hFF);
        status_read_cmd;
        chk("busy", rx[0], 1);
        idle;
        chk("status_write_cmd", rx, 8'h8C);
        wp_n = 1'b0;
        wen;
        status_write_cmd(8'h00);
        idle;
        chk("hw_lock", rx, 8'h8E);
        wp_n = 1'b1;
        status_write_cmd(8'h00);
        idle;
        chk("hw_free", rx, 0);
        $display("test status done");
        for (i = 0; i < 12; i = i + 1) begin
            bp = i[1:0];
            r = $random(seed);
            if (i >= 8)
                r[16:0] = 17'h17FFF + i[0];
            wen;
            status_write_cmd({4'h0, bp, 2'h0});
            idle;
            wen;
            n = reqs;
            op({r[31] ? 8'h42 : 8'hD8, r[23:0], 8'h00}, 32);
            idle;
            chk("erase_go", reqs - n, !prot(bp, r[16:0]));
            chk("erase_wel", rx, {4'h0, bp, 2'h0});
            if (!prot(bp, r[16:0]))
                chk("erase_at", {last_kind, last_addr}, {r[31] ? 2'h0 : 2'h1, r[16:0]});
        end
        wen;
        n = reqs;
        op({8'hC7, 32'h0}, 8);
        idle;
        chk("chip_prot", reqs - n, 0);
        status_write_cmd(8'h00);
        idle;
        wen;
        op({8'hC7, 32'h0}, 8);
        wen;
        op({8'h42, 32'h0}, 32);
        idle;
        chk("chip_go", reqs - n, 1);
        chk("chip_kind", last_kind, 2);
        chk("chip_wel", rx, 0);
        $display("test erase done");
        op({8'hB9, 32'h0}, 8);
        chk("pd_on", power_down_ff, 1);
        u_host.tick(200);
        chk("pd_low", low_power_ff, 1);
        wen;
        n = reqs;
        op({8'h42, 32'h0}, 32);
        chk("pd_ignore", reqs - n, 0);
        op({8'hAB, 32'h0}, 40);
        chk("signature", rx, 8'hC3);
        u_host.tick(20);
        chk("pd_off", power_down_ff, 0);
        status_read_cmd;
        chk("wel_pd", rx, 0);
        wen;
        op({8'hB9, 32'h0}, 8);
        reset = 1'b1;
        u_host.tick(2);
        reset = 1'b0;
        chk("pd_reset", {power_down_ff, low_power_ff, status_ff}, 0);
        status_read_cmd;
        chk("sr_reset", rx, 0);
        $display("test power done");
        end_sim;
    end
endmodule // tb
